// >>> led_receiver_model.sv
// Behavioural LED and photodiode receiver model that feeds the converter port
`default_nettype none

module led_receiver_model
  import prox_timing_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic led_drive,
  input wire logic sample_strobe,
  input wire logic [INTEG_W-1:0] integ_sel,
  input wire logic [RESULT_W-1:0] level,
  output var conv_out_t conv_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] lit_count;
  initial conv_out = '0;
  always @(posedge sys_clk) begin
    conv_out.valid <= 1'b0;
    if (sys_rst) begin
      lit_count <= 2'h0;
    end else if (sample_strobe && led_drive) begin
      lit_count <= lit_count + 2'h1;
      if (lit_count == 2'h3) begin
        conv_out <= '{1'b1, integ_sel, level};
      end
    end
  end
endmodule

`default_nettype wire

// >>> prox_timing_pkg.sv
// Constants, types and helpers for the proximity LED pulse timing block
// How it works
// - LED pulse rate is the 4 MHz reference divided by the divider register.
// - Divider resets to sixteen, giving 250 KHz, a 4 us period.
// - Divisors two to thirty-one cover roughly 129 KHz up to 2 MHz.
// - Receiver samples after a programmable delay from every LED edge when the delay is below the LED on time.
// - Sample delay register resets to five, a 500 ns delay.
// - LED drive is modulated at the pulse rate to light the target.
// - With 300 us integration the result is an unsigned 12-bit value.
// - Result width grows with integration time up to 16 bits.
// - Final measurement is stored in the result register for host reads.
// - Divider uses the low five register bits; upper three ignored.
// - Sample delay code uses the low five register bits.
`default_nettype none

package prox_timing_pkg;

  localparam int SYS_CLK_MHZ = 250;
  localparam int REF_CLK_MHZ = 4;
  localparam int TB_STEP_NS = 125;
  localparam int TB_MHZ = 1000 / TB_STEP_NS;
  localparam int ACC_W = 9;
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(SYS_CLK_MHZ);
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(TB_MHZ);
  localparam logic [ACC_W-1:0] ACC_RESET = 9'h000;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] LED_PULSE_DIVIDER_ADDR = 8'h0D;
  localparam logic [ADDR_W-1:0] RECEIVER_SAMPLE_DELAY_ADDR = 8'h0E;
  localparam logic [ADDR_W-1:0] PROXIMITY_RESULT_MSB_ADDR = 8'h41;
  localparam logic [ADDR_W-1:0] PROXIMITY_RESULT_LSB_ADDR = 8'h42;

  localparam int FIELD_W = 5;
  localparam int FIELD_LSB = 0;
  localparam logic [FIELD_W-1:0] DIV_RESET = 5'h10;
  localparam logic [FIELD_W-1:0] DIV_MIN = 5'h02;
  localparam logic [FIELD_W-1:0] DIV_MAX = 5'h1F;
  localparam logic [FIELD_W-1:0] DELAY_RESET = 5'h05;
  localparam logic [FIELD_W-1:0] DELAY_NONE_MAX = 5'h01;

  localparam int PHASE_W = FIELD_W + 1;
  localparam logic [PHASE_W-1:0] PHASE_RESET = 6'h3F;

  localparam int RESULT_W = 16;
  localparam int INTEG_W = 3;
  localparam logic [INTEG_W-1:0] INTEG_300US = 3'h0;
  localparam logic [INTEG_W-1:0] INTEG_600US = 3'h1;
  localparam logic [INTEG_W-1:0] INTEG_1200US = 3'h2;
  localparam logic [INTEG_W-1:0] INTEG_1800US = 3'h3;
  localparam logic [INTEG_W-1:0] INTEG_2400US = 3'h4;
  localparam logic [INTEG_W-1:0] INTEG_3600US = 3'h5;
  localparam logic [RESULT_W-1:0] MASK_12B = 16'h0FFF;
  localparam logic [RESULT_W-1:0] MASK_13B = 16'h1FFF;
  localparam logic [RESULT_W-1:0] MASK_14B = 16'h3FFF;
  localparam logic [RESULT_W-1:0] MASK_15B = 16'h7FFF;
  localparam logic [RESULT_W-1:0] MASK_16B = 16'hFFFF;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [INTEG_W-1:0] integ_sel;
    logic [RESULT_W-1:0] data;
  } conv_out_t;

  // Valid result bits for each integration time
  function automatic logic [RESULT_W-1:0] result_mask(input logic [INTEG_W-1:0] sel);
    logic [RESULT_W-1:0] m;
    m = MASK_16B;
    unique case (sel)
      INTEG_300US: m = MASK_12B;
      INTEG_600US: m = MASK_13B;
      INTEG_1200US: m = MASK_14B;
      INTEG_1800US, INTEG_2400US: m = MASK_15B;
      INTEG_3600US: m = MASK_16B;
      default: m = MASK_16B;
    endcase
    return m;
  endfunction

endpackage

`default_nettype wire

// >>> proximity_led_pulse_timing.sv
// LED pulse divider, receiver sample strobe timing and result register
`default_nettype none

module proximity_led_pulse_timing
  import prox_timing_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire reg_req_t reg_req,
  output logic [DATA_W-1:0] reg_rdata,
  input wire conv_out_t conv_out,
  output logic led_drive,
  output logic sample_strobe
);

  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic [ACC_W-1:0] acc_sum;
  logic tb_tick;
  logic [FIELD_W-1:0] div_reg;
  logic [FIELD_W-1:0] div_next;
  logic [FIELD_W-1:0] delay_reg;
  logic [FIELD_W-1:0] delay_next;
  logic [FIELD_W-1:0] div_eff;
  logic [FIELD_W-1:0] delay_eff;
  logic [PHASE_W-1:0] period_last;
  logic [PHASE_W-1:0] phase_reg;
  logic [PHASE_W-1:0] phase_next;
  logic led_reg;
  logic led_next;
  logic sample_reg;
  logic sample_next;
  logic [RESULT_W-1:0] result_reg;
  logic [RESULT_W-1:0] result_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // Timebase: 8 MHz ticks from 250 MHz by fractional accumulation
  always_comb begin
    acc_sum = acc_reg + ACC_STEP;
    tb_tick = (acc_sum >= ACC_MOD);
    acc_next = tb_tick ? acc_sum - ACC_MOD : acc_sum;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      acc_reg <= ACC_RESET;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // Control registers
  always_comb begin
    div_next = div_reg;
    delay_next = delay_reg;
    if (reg_req.wr && reg_req.addr == LED_PULSE_DIVIDER_ADDR) begin
      div_next = reg_req.wdata[FIELD_LSB +: FIELD_W];
    end
    if (reg_req.wr && reg_req.addr == RECEIVER_SAMPLE_DELAY_ADDR) begin
      delay_next = reg_req.wdata[FIELD_LSB +: FIELD_W];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div_reg <= DIV_RESET;
      delay_reg <= DELAY_RESET;
    end else begin
      div_reg <= div_next;
      delay_reg <= delay_next;
    end
  end

  // Pulse phase: one period is 2 x divisor timebase ticks, LED on in first half
  always_comb begin
    div_eff = (div_reg < DIV_MIN) ? DIV_MIN : div_reg;
    delay_eff = (delay_reg <= DELAY_NONE_MAX) ? '0 : delay_reg - 5'h01;
    period_last = {div_eff, 1'b0} - 6'h01;
    phase_next = phase_reg;
    if (tb_tick) begin
      phase_next = (phase_reg >= period_last) ? '0 : phase_reg + 6'h01;
    end
    led_next = (phase_next < {1'b0, div_eff});
    // Sample a fixed delay after each rising and falling LED edge while delay_eff is below div_eff
    sample_next = tb_tick && (phase_next == {1'b0, delay_eff} ||
                              phase_next == {1'b0, div_eff} + {1'b0, delay_eff});
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_reg <= PHASE_RESET;
      led_reg <= 1'b0;
      sample_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      led_reg <= led_next;
      sample_reg <= sample_next;
    end
  end

  // Result capture and register reads
  always_comb begin
    result_next = result_reg;
    if (conv_out.valid) begin
      result_next = conv_out.data & result_mask(conv_out.integ_sel);
    end
    rdata_next = rdata_reg;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        LED_PULSE_DIVIDER_ADDR: rdata_next = {3'h0, div_reg};
        RECEIVER_SAMPLE_DELAY_ADDR: rdata_next = {3'h0, delay_reg};
        PROXIMITY_RESULT_MSB_ADDR: rdata_next = result_reg[RESULT_W-1 -: DATA_W];
        PROXIMITY_RESULT_LSB_ADDR: rdata_next = result_reg[DATA_W-1:0];
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      result_reg <= RESULT_RESET;
      rdata_reg <= 8'h00;
    end else begin
      result_reg <= result_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign led_drive = led_reg;
  assign sample_strobe = sample_reg;

  // Checks
  sequence led_rise_s;
    $rose(led_reg);
  endsequence

  sequence wrap_s;
    $past(phase_reg) >= $past(period_last) && phase_reg == '0;
  endsequence

  chk_div_reset: assert property (@(posedge sys_clk) $past(sys_rst) && !sys_rst |-> div_reg == DIV_RESET)
    else $error("divider not at reset value");
  chk_delay_reset: assert property (@(posedge sys_clk) $past(sys_rst) && !sys_rst |-> delay_reg == DELAY_RESET)
    else $error("sample delay not at reset value");
  chk_led_period_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
    led_rise_s ##0 $past(div_reg) == $past(div_reg, 2) |-> wrap_s)
    else $error("LED rose away from period wrap");
  chk_led_on_width: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(led_reg) && $past(div_reg) == $past(div_reg, 2) |-> phase_reg == {1'b0, $past(div_eff)})
    else $error("LED on time differs from divisor");
  chk_divisor_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
    div_eff >= DIV_MIN && div_eff <= DIV_MAX)
    else $error("divisor out of range");
  chk_sample_phase: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sample_reg |-> (phase_reg == {1'b0, $past(delay_eff)} ||
                    phase_reg == {1'b0, $past(div_eff)} + {1'b0, $past(delay_eff)}))
    else $error("sample strobe at wrong phase");
  chk_no_delay_edge: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sample_reg && $past(delay_reg) <= DELAY_NONE_MAX && $past(phase_reg) != PHASE_RESET
    |-> led_reg != $past(led_reg))
    else $error("zero delay sample not on LED edge");
  chk_timebase_gap: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tb_tick |=> !tb_tick [*8])
    else $error("timebase ticks too close");
  chk_div_field: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_req.wr && reg_req.addr == LED_PULSE_DIVIDER_ADDR |=> div_reg == $past(reg_req.wdata[4:0]))
    else $error("divider write not stored");
  chk_delay_field: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_req.wr && reg_req.addr == RECEIVER_SAMPLE_DELAY_ADDR |=> delay_reg == $past(reg_req.wdata[4:0]))
    else $error("delay write not stored");
  chk_result_width: assert property (@(posedge sys_clk) disable iff (sys_rst)
    conv_out.valid && conv_out.integ_sel == INTEG_300US |=> result_reg[15:12] == 4'h0)
    else $error("12-bit result has high bits set");
  chk_result_store: assert property (@(posedge sys_clk) disable iff (sys_rst)
    conv_out.valid |=> result_reg == ($past(conv_out.data) & result_mask($past(conv_out.integ_sel))))
    else $error("result not stored at its resolution");
  chk_result_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_req.rd && reg_req.addr == PROXIMITY_RESULT_MSB_ADDR |=> reg_rdata == $past(result_reg[15:8]))
    else $error("result high byte read wrong");

endmodule

`default_nettype wire

// >>> proximity_led_pulse_timing_tb_top.sv
// Self-checking bench for the LED pulse timing block
`default_nettype none

module proximity_led_pulse_timing_tb_top;
  import prox_timing_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  reg_req_t reg_req = '0;
  logic [DATA_W-1:0] reg_rdata;
  conv_out_t conv_out;
  logic led_drive;
  logic sample_strobe;
  logic [INTEG_W-1:0] integ_sel = 3'h0;
  logic [RESULT_W-1:0] level = 16'hFA5F;
  int fail_count = 0;
  int check_count = 0;
  int widths [8] = '{12, 13, 14, 15, 15, 16, 16, 16};
  always #2 sys_clk = ~sys_clk;
  proximity_led_pulse_timing dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .conv_out(conv_out), .led_drive(led_drive), .sample_strobe(sample_strobe));
  led_receiver_model far_side (.sys_clk(sys_clk), .sys_rst(sys_rst), .led_drive(led_drive),
    .sample_strobe(sample_strobe), .integ_sel(integ_sel), .level(level), .conv_out(conv_out));
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] near(input int a, input int b, input int tol);
    return ((a - b) <= tol && (b - a) <= tol) ? 16'h0001 : 16'h0000;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(negedge sys_clk);
    reg_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge sys_clk);
    reg_req <= '0;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic wait_led(input logic lvl, output int n);
    n = 0;
    while (led_drive !== lvl) begin
      @(negedge sys_clk);
      n++;
      if (n > 4000) begin
        fail_count++;
        $display("wrong value at %0t: LED level wait ran out", $time);
        end_sim();
      end
    end
  endtask
  // Measures delay, high time and period, in cycles, from one LED rise
  task automatic timing(input int d, input int code);
    int n, dly, hi, per;
    wait_led(1'b0, n);
    wait_led(1'b1, n);
    dly = 0;
    while (sample_strobe !== 1'b1 && dly < 4000) begin
      @(negedge sys_clk);
      dly++;
    end
    if (dly >= 4000) begin
      fail_count++;
      $display("wrong value at %0t: sample strobe wait ran out", $time);
      end_sim();
    end
    wait_led(1'b0, hi);
    hi += dly;
    wait_led(1'b1, per);
    per += hi;
    chk(near(2 * per, d * 125, 2), 16'h0001);
    chk(near(4 * hi, d * 125, 6), 16'h0001);
    chk(near(4 * dly, (code <= 1) ? 0 : (code - 1) * 125, 6), 16'h0001);
  endtask
  task automatic result_check(input int sel);
    int n;
    logic [15:0] exp;
    integ_sel <= 3'(sel);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (conv_out.valid !== 1'b1 && n < 4000);
      if (n >= 4000) begin
        fail_count++;
        end_sim();
      end
    end
    @(negedge sys_clk);
    exp = level & 16'((17'h00001 << widths[sel]) - 17'h00001);
    rd(8'h41, exp[15:8]);
    rd(8'h42, exp[7:0]);
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h0D, 8'h10);
    rd(8'h0E, 8'h05);
    rd(8'h20, 8'h00);
    timing(16, 5);
    wr(8'h0D, 8'hE8);
    wr(8'h0E, 8'hE3);
    rd(8'h0D, 8'h08);
    rd(8'h0E, 8'h03);
    timing(8, 3);
    wr(8'h0D, 8'h02);
    wr(8'h0E, 8'h01);
    timing(2, 1);
    wr(8'h0D, 8'h1F);
    wr(8'h0E, 8'h1F);
    timing(31, 31);
    wr(8'h0D, 8'h04);
    wr(8'h0E, 8'h00);
    timing(4, 0);
    for (int s = 0; s < 8; s++) begin
      result_check(s);
    end
    end_sim();
  end
endmodule

`default_nettype wire
